// *** rpd_top.sv ***
// Reset and power-down control with an APB register view of the reset classes.
// Assumes pins arrive asynchronously and pclk is 20 MHz.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rpd_top #(
   parameter int settle_cycles = rpd_pkg::settle_cycles
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_reset_n,
   input wire logic partial_reset_n,
   input wire logic power_down_pin,
   input wire logic regulator_bypass_strap,
   output logic switched_analog_supply_on,
   output logic osc_enable,
   output logic regulator_enable,
   output logic core_supply_internal,
   output logic global_rst_out_n,
   output logic core_rst_out_n
);
   logic global_rst_n;
   logic core_rst_n;
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_f;
   logic pwd_f;
   logic strap_f;
   logic prst_f;
   logic pwd_prev;
   logic prst_prev;
   logic [31:0] core_scratch;
   logic [31:0] rtc_alarm;
   logic [31:0] wake_cfg;
   logic [31:0] gpio_ctrl;
   logic [31:0] rtc_count;
   logic [31:0] settle_cnt;
   logic lost_flag;
   logic settle_err;
   logic wr_en;
   logic core_lost;
   logic lost_evt;
   logic settle_evt;
   logic [31:0] status_word;
   logic [31:0] next_rdata;
   logic next_err;

   // Global class follows presetn and the global pin; core class also follows partial pin
   rpd_rst_sync #(.stages(rpd_pkg::rst_sync_stages)) u_global_sync (
      .clk(pclk),
      .clear_n(presetn & global_reset_n),
      .rst_n(global_rst_n)
   );

   rpd_rst_sync #(.stages(rpd_pkg::rst_sync_stages)) u_core_sync (
      .clk(pclk),
      .clear_n(presetn & global_reset_n & partial_reset_n),
      .rst_n(core_rst_n)
   );

   // Three-flop pin filter: a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Partial reset idles high; a low start would fake a release edge for the settle watch
         pin_s1 <= 3'h4;
         pin_s2 <= 3'h4;
         pin_s3 <= 3'h4;
         pin_f <= 3'h4;
      end else begin
         pin_s1 <= {partial_reset_n, regulator_bypass_strap, power_down_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
      end
   end

   always_comb begin
      pwd_f = pin_f[0];
      strap_f = pin_f[1];
      prst_f = pin_f[2];
   end

   // Supply and oscillator controls, plus the registered reset outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switched_analog_supply_on <= 1'b0;
         osc_enable <= 1'b0;
         regulator_enable <= 1'b0;
         core_supply_internal <= 1'b0;
         global_rst_out_n <= 1'b0;
         core_rst_out_n <= 1'b0;
      end else begin
         switched_analog_supply_on <= ~pwd_f;
         osc_enable <= ~pwd_f;
         regulator_enable <= ~strap_f & ~pwd_f;
         core_supply_internal <= ~strap_f;
         global_rst_out_n <= global_rst_n;
         core_rst_out_n <= core_rst_n;
      end
   end

   // Core contents vanish only when the internal regulator is switched off
   always_comb begin
      core_lost = pwd_f & ~strap_f;
      wr_en = psel & penable & pready & pwrite;
   end

   // Core class: defaulted by either reset and by regulator power loss
   always_ff @(posedge pclk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         core_scratch <= rpd_pkg::core_scratch_rst;
      end else if (core_lost) begin
         core_scratch <= rpd_pkg::core_scratch_rst;
      end else if (wr_en && paddr == rpd_pkg::core_scratch_off) begin
         core_scratch <= pwdata;
      end
   end

   // Retained class: only the global reset defaults these
   always_ff @(posedge pclk or negedge global_rst_n) begin
      if (!global_rst_n) begin
         rtc_alarm <= rpd_pkg::rtc_alarm_rst;
         wake_cfg <= rpd_pkg::wake_cfg_rst;
         gpio_ctrl <= rpd_pkg::gpio_ctrl_rst;
      end else if (wr_en) begin
         if (paddr == rpd_pkg::rtc_alarm_off) begin
            rtc_alarm <= pwdata;
         end
         if (paddr == rpd_pkg::wake_cfg_off) begin
            wake_cfg <= pwdata;
         end
         if (paddr == rpd_pkg::gpio_ctrl_off) begin
            gpio_ctrl <= pwdata;
         end
      end
   end

   // Real-time counter keeps running through partial reset and power-down
   always_ff @(posedge pclk or negedge global_rst_n) begin
      if (!global_rst_n) begin
         rtc_count <= rpd_pkg::rtc_count_rst;
      end else if (wr_en && paddr == rpd_pkg::rtc_count_off) begin
         rtc_count <= pwdata;
      end else begin
         rtc_count <= rtc_count + 32'h00000001;
      end
   end

   // Settling watch on the controller's exit sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt <= 32'h00000000;
         pwd_prev <= 1'b0;
         prst_prev <= 1'b1;
      end else begin
         pwd_prev <= pwd_f;
         prst_prev <= prst_f;
         if (pwd_f) begin
            settle_cnt <= 32'h00000000;
         end else if (settle_cnt < 32'(settle_cycles)) begin
            settle_cnt <= settle_cnt + 32'h00000001;
         end
      end
   end

   always_comb begin
      lost_evt = core_lost;
      // Violation: partial reset not low at exit, or released before settling
      settle_evt = ~strap_f & ~pwd_f & ((pwd_prev & prst_f) |
                   (prst_f & ~prst_prev & (settle_cnt < 32'(settle_cycles))));
   end

   // Sticky diagnostic flags, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge global_rst_n) begin
      if (!global_rst_n) begin
         lost_flag <= 1'b0;
         settle_err <= 1'b0;
      end else begin
         if (lost_evt) begin
            lost_flag <= 1'b1;
         end else if (wr_en && paddr == rpd_pkg::status_off && pwdata[rpd_pkg::st_lost_bit]) begin
            lost_flag <= 1'b0;
         end
         if (settle_evt) begin
            settle_err <= 1'b1;
         end else if (wr_en && paddr == rpd_pkg::status_off && pwdata[rpd_pkg::st_settle_bit]) begin
            settle_err <= 1'b0;
         end
      end
   end

   always_comb begin
      status_word = 32'h00000000;
      status_word[rpd_pkg::st_pwd_bit] = pwd_f;
      status_word[rpd_pkg::st_strap_bit] = strap_f;
      status_word[rpd_pkg::st_analog_bit] = switched_analog_supply_on;
      status_word[rpd_pkg::st_osc_bit] = osc_enable;
      status_word[rpd_pkg::st_reg_bit] = regulator_enable;
      status_word[rpd_pkg::st_lost_bit] = lost_flag;
      status_word[rpd_pkg::st_settle_bit] = settle_err;
   end

   always_comb begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      case (paddr)
         rpd_pkg::core_scratch_off: next_rdata = core_scratch;
         rpd_pkg::rtc_alarm_off: next_rdata = rtc_alarm;
         rpd_pkg::wake_cfg_off: next_rdata = wake_cfg;
         rpd_pkg::gpio_ctrl_off: next_rdata = gpio_ctrl;
         rpd_pkg::status_off: next_rdata = status_word;
         rpd_pkg::rtc_count_off: next_rdata = rtc_count;
         default: next_err = 1'b1;
      endcase
   end

   // No wait state: answer is prepared in the setup cycle, given in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~penable;
         if (psel && !penable) begin
            pslverr <= next_err;
            prdata <= pwrite ? 32'h00000000 : next_rdata;
         end else begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
         end
      end
   end
endmodule
`default_nettype wire

// *** rpd_pkg.sv ***
// Constants shared by the reset and power-down control block.
// Assumes a 20 MHz pclk and a 32-bit APB register bus.
package rpd_pkg;
   // Register byte offsets
   localparam logic [11:0] core_scratch_off = 12'h000;
   localparam logic [11:0] rtc_alarm_off = 12'h004;
   localparam logic [11:0] wake_cfg_off = 12'h008;
   localparam logic [11:0] gpio_ctrl_off = 12'h00c;
   localparam logic [11:0] status_off = 12'h010;
   localparam logic [11:0] rtc_count_off = 12'h014;

   // Reset values
   localparam logic [31:0] core_scratch_rst = 32'h00000000;
   localparam logic [31:0] rtc_alarm_rst = 32'h00000000;
   localparam logic [31:0] wake_cfg_rst = 32'h00000000;
   localparam logic [31:0] gpio_ctrl_rst = 32'h00000000;
   localparam logic [31:0] rtc_count_rst = 32'h00000000;

   // Status field positions
   localparam int st_pwd_bit = 0;
   localparam int st_strap_bit = 1;
   localparam int st_analog_bit = 2;
   localparam int st_osc_bit = 3;
   localparam int st_reg_bit = 4;
   localparam int st_lost_bit = 5;
   localparam int st_settle_bit = 6;

   // Regulator settling time after leaving power-down
   localparam int settle_time_ms = 10;
   localparam int clk_hz = 20000000;
   localparam int settle_cycles = (settle_time_ms * clk_hz) / 1000;

   // Flops in each reset release synchroniser
   localparam int rst_sync_stages = 2;
endpackage

// *** rpd_rst_sync.sv ***
// Reset synchroniser: asserts at once, releases on a pclk edge.
// Assumes clear_n is an asynchronous, active-low reset request.
`timescale 1ns/1ps
`default_nettype none
module rpd_rst_sync #(
   parameter int stages = 2
) (
   input wire logic clk,
   input wire logic clear_n,
   output var logic rst_n
);
   logic [stages-1:0] chain;

   always_ff @(posedge clk or negedge clear_n) begin
      if (!clear_n) begin
         chain <= '0;
      end else begin
         chain <= {chain[stages-2:0], 1'b1};
      end
   end

   // Only the last stage leaves the module; earlier ones may be metastable
   always_comb begin
      rst_n = chain[stages-1];
   end
endmodule
`default_nettype wire

// *** rpd_monitor.sv ***
// Checker on the top ports: pin to output timing and reset release.
// Assumes pin changes reach outputs 5 edges on and a reset release reaches them 3 edges on.
`timescale 1ns/1ps
`default_nettype none
module rpd_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic global_reset_n,
   input wire logic partial_reset_n,
   input wire logic power_down_pin,
   input wire logic regulator_bypass_strap,
   input wire logic switched_analog_supply_on,
   input wire logic osc_enable,
   input wire logic regulator_enable,
   input wire logic core_supply_internal,
   input wire logic global_rst_out_n,
   input wire logic core_rst_out_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_off; $rose(power_down_pin) |-> ##5 !switched_analog_supply_on && !osc_enable; endproperty
   a_off: assert property (p_off) else $error("analog on");
   property p_on; $fell(power_down_pin) |->
      !switched_analog_supply_on [*5] ##1 switched_analog_supply_on; endproperty
   a_on: assert property (p_on) else $error("analog late");
   property p_reg; $rose(power_down_pin) |-> ##5 !regulator_enable; endproperty
   a_reg: assert property (p_reg) else $error("regulator on");
   property p_int; regulator_enable |-> core_supply_internal && osc_enable; endproperty
   a_int: assert property (p_int) else $error("regulator source");
   property p_sel; $changed(regulator_bypass_strap) |->
      ##5 core_supply_internal != regulator_bypass_strap; endproperty
   a_sel: assert property (p_sel) else $error("supply select");
   property p_glob; $fell(global_reset_n) |-> ##1 !global_rst_out_n && !core_rst_out_n; endproperty
   a_glob: assert property (p_glob) else $error("global reset");
   property p_rel; $rose(global_reset_n) |-> !global_rst_out_n [*3] ##1 global_rst_out_n; endproperty
   a_rel: assert property (p_rel) else $error("reset release");
   property p_part; $fell(partial_reset_n) && global_rst_out_n |->
      ##1 !core_rst_out_n && global_rst_out_n; endproperty
   a_part: assert property (p_part) else $error("partial reset");
endmodule
bind rpd_top rpd_monitor i_mon (.*);
`default_nettype wire

// *** rpd_ctrl_model.sv ***
// Controller model: drives the reset, power-down and strap pins.
// Assumes tasks are entered just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module rpd_ctrl_model #(
   parameter int settle_cycles = 20
) (
   input wire logic pclk,
   output logic global_reset_n,
   output logic partial_reset_n,
   output logic power_down_pin,
   output logic regulator_bypass_strap
);
   initial {global_reset_n, partial_reset_n, power_down_pin, regulator_bypass_strap} = 4'hd;
   task automatic set_strap(input logic v);
      regulator_bypass_strap <= v;
      repeat (8) @(posedge pclk);
   endtask
   task automatic pulse(input logic glob);
      {global_reset_n, partial_reset_n} <= glob ? 2'h1 : 2'h2;
      repeat (6) @(posedge pclk);
      {global_reset_n, partial_reset_n} <= 2'h3;
      repeat (8) @(posedge pclk);
   endtask
   // Without ord the partial reset is skipped: fine on external supply, a misuse on the regulator
   task automatic power_cycle(input logic ord);
      power_down_pin <= 1'h1;
      repeat (12) @(posedge pclk);
      partial_reset_n <= !ord;
      repeat (6) @(posedge pclk);
      power_down_pin <= 1'h0;
      repeat (settle_cycles + 2) @(posedge pclk);
      partial_reset_n <= 1'h1;
      repeat (8) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// *** rpd_tb.sv ***
// Testbench: APB accesses around pin sequences from the controller model.
// Assumes settle_cycles cut to 20 so power cycles stay short.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [11:0] st = rpd_pkg::status_off;
   localparam logic [11:0] offs [4] = '{rpd_pkg::core_scratch_off, rpd_pkg::rtc_alarm_off,
      rpd_pkg::wake_cfg_off, rpd_pkg::gpio_ctrl_off};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   wire logic global_reset_n, partial_reset_n, power_down_pin, regulator_bypass_strap;
   wire logic switched_analog_supply_on, osc_enable, regulator_enable, core_supply_internal;
   wire logic global_rst_out_n, core_rst_out_n;
   int bad_count = 0;
   int num_checks = 0;
   rpd_top #(.settle_cycles(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .global_reset_n, .partial_reset_n, .power_down_pin, .regulator_bypass_strap,
      .switched_analog_supply_on, .osc_enable, .regulator_enable, .core_supply_internal,
      .global_rst_out_n, .core_rst_out_n);
   rpd_ctrl_model #(.settle_cycles(20)) i_ctrl (.pclk, .global_reset_n, .partial_reset_n,
      .power_down_pin, .regulator_bypass_strap);
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask
   // Pin outputs in order: analog, oscillator, regulator, internal supply, global and core reset
   task automatic chk_pins(input logic [5:0] e);
      logic [5:0] g;
      g = {switched_analog_supply_on, osc_enable, regulator_enable, core_supply_internal,
         global_rst_out_n, core_rst_out_n};
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected pins: expected %h, seen %h", e, g);
      end
   endtask
   // Error response lands in bit 31 of q, so a wrong pslverr also shows as a mismatch
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      q = prdata | {pslverr, 31'h0};
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic wr4;
      for (int i = 0; i < 4; i++) begin
         xfer(1'h1, offs[i], {20'h5a000, offs[i]});
      end
   endtask
   task automatic chk4(input logic core, input logic kept);
      for (int i = 0; i < 4; i++) begin
         rc(offs[i], ((i == 0) ? core : kept) ? {20'h5a000, offs[i]} : 32'h0);
      end
   endtask
   initial begin
      presetn = 1'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      repeat (4) @(posedge pclk);
      chk4(1'h0, 1'h0);
      chk_pins(6'h33);
      rc(12'h020, 32'h80000000);
      wr4();
      xfer(1'h1, rpd_pkg::rtc_count_off, 32'h00000100);
      i_ctrl.pulse(1'h0);
      // Counter runs on: 15 increments land after the write edge and before the read setup edge
      rc(rpd_pkg::rtc_count_off, 32'h0000010f);
      chk4(1'h0, 1'h1);
      wr4();
      i_ctrl.pulse(1'h1);
      chk4(1'h0, 1'h0);
      $display("test reset classes done");
      wr4();
      i_ctrl.power_cycle(1'h0);
      chk4(1'h1, 1'h1);
      rc(st, 32'h0e);
      i_ctrl.set_strap(1'h0);
      rc(st, 32'h1c);
      chk_pins(6'h3f);
      wr4();
      i_ctrl.power_cycle(1'h1);
      chk4(1'h0, 1'h1);
      rc(st, 32'h3c);
      xfer(1'h1, st, 32'h60);
      rc(st, 32'h1c);
      i_ctrl.power_cycle(1'h0);
      rc(st, 32'h7c);
      $display("test power-down done");
      print_verdict();
   end
   // The run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
